// >>> hdl/chg_setpoint_consts.svh
// offsets, field positions, defaults and limits of the charge voltage setpoint bank
`ifndef CHG_SETPOINT_CONSTS_SVH
`define CHG_SETPOINT_CONSTS_SVH
`define CVL_ADDR_LO 8'h04
`define CVL_ADDR_HI 8'h05
`define SVF_ADDR_LO 8'h0C
`define SVF_ADDR_HI 8'h0D
`define CCS_ADDR_LO 8'h02
`define CCS_ADDR_HI 8'h03
`define CVL_FIELD_MASK 16'h7FF0
`define CVL_RSVD_HI_MASK 8'h80
`define SVF_FIELD_MASK 16'h3F00
`define SVF_RSVD_HI_MASK 8'hC0
`define CVL_MIN_MV 16'd1024
`define CVL_MAX_MV 16'd19200
`define SVF_MIN_MV 16'd1024
`define SVF_MAX_MV 16'd16128
`define CVL_DEF_1S 16'd4192
`define CVL_DEF_2S 16'd8400
`define CVL_DEF_3S 16'd12592
`define CVL_DEF_4S 16'd16800
`define SVF_DEF_1S 16'd3584
`define SVF_DEF_2S 16'd6144
`define SVF_DEF_3S 16'd9216
`define SVF_DEF_4S 16'd12288
`define STRAP_SETTLE 3'h4
`endif

// >>> hdl/chg_setpoint_pkg.sv
// types shared by the setpoint bank
package chg_setpoint_pkg;
    typedef logic [1:0] cell_count_t;
    typedef logic [15:0] word_t;
endpackage : chg_setpoint_pkg

// >>> hdl/pair_capture_if.sv
// byte pair assembly signals between the bank and its pair collector
`timescale 1ns/100ps
interface pair_capture_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] data;
    logic done;
    logic [7:0] base;
    logic [15:0] word;
    modport collector (input wr_en, input addr, input data, output done, output base, output word);
    modport bank (output wr_en, output addr, output data, input done, input base, input word);
endinterface : pair_capture_if

// >>> hdl/byte_pair_collector.sv
// collects the low byte then the high byte of a 16-bit setpoint
`timescale 1ns/100ps
module byte_pair_collector (
    input wire logic clk_in,
    input wire logic reset_in,
    pair_capture_if.collector pc
);
    logic [7:0] low_byte;
    logic [7:0] low_base;
    logic low_held;

    // hold the even byte; the word is complete on the odd byte of the same pair
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            low_byte <= 8'h00;
            low_base <= 8'h00;
            low_held <= 1'b0;
            pc.done <= 1'b0;
            pc.base <= 8'h00;
            pc.word <= 16'h0000;
        end else begin
            pc.done <= 1'b0;
            if (pc.wr_en && !pc.addr[0]) begin
                low_byte <= pc.data;
                low_base <= pc.addr;
                low_held <= 1'b1;
            end else if (pc.wr_en && pc.addr[0]) begin
                low_held <= 1'b0;
                // high byte without its matching low byte is dropped
                if (low_held && low_base == {pc.addr[7:1], 1'b0}) begin
                    pc.done <= 1'b1;
                    pc.base <= low_base;
                    pc.word <= {pc.data, low_byte};
                end
            end
        end
    end
endmodule : byte_pair_collector

// >>> hdl/charge_voltage_setpoint_regs.sv
// setpoint register bank: charge voltage limit and system voltage floor
`timescale 1ns/100ps
`include "chg_setpoint_consts.svh"
// Notes on behaviour
// - each setpoint travels as one word, high byte at the odd address, low byte at the even one.
// - the charge voltage limit covers 1.024 V to 19.200 V in 16 mV steps.
// - a non-zero charge voltage limit write outside 1.024 V to 19.200 V is dropped and the old value stays.
// - the charge voltage limit field is word bits 14 to 4, weights 16384 mV down to 16 mV.
// - after reset the charge voltage limit is 4192, 8400, 12592 or 16800 mV for one to four cells.
// - after reset and whenever charging is off, the regulation target is the charge voltage limit.
// - with input power good, a non-zero current write ahead of any voltage write starts charging at once.
// - writing zero to the voltage limit reloads the cell default and zeroes the current setpoint.
// - a one in a reserved high-byte bit of either voltage register makes the write invalid.
// - reserved low bits are ignored: bits 3 to 0 of the limit and the floor's whole low byte.
// - the system voltage floor covers 1.024 V to 16.128 V in 256 mV steps.
// - a floor write outside 1.024 V to 16.128 V is dropped.
// - the floor field is word bits 13 to 8, weights 8192 mV down to 256 mV.
// - after reset the floor is 3.584, 6.144, 9.216 or 12.288 V for one to four cells.
module charge_voltage_setpoint_regs
    import chg_setpoint_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [1:0] cell_count_select_pin_in,
    input wire logic input_power_good_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    output logic [15:0] charge_voltage_limit_out,
    output logic [15:0] system_voltage_floor_out,
    output logic [15:0] charge_current_setpoint_out,
    output logic charge_enable_out,
    output logic [15:0] regulation_target_out
);
    pair_capture_if pc ();
    logic [2:0] strap_sync [2];
    logic strap_bit [2];
    cell_count_t cells;
    logic first_cycle;
    word_t cvl_word;
    word_t svf_word;
    word_t default_cvl;
    word_t default_svf;
    logic cvl_ok;
    logic svf_ok;

    // cell defaults, mV values are the register codes since the lsb weight equals its mV
    function automatic word_t cvl_default(input cell_count_t c);
        case (c)
            2'h0: cvl_default = `CVL_DEF_1S;
            2'h1: cvl_default = `CVL_DEF_2S;
            2'h2: cvl_default = `CVL_DEF_3S;
            default: cvl_default = `CVL_DEF_4S;
        endcase
    endfunction : cvl_default

    function automatic word_t svf_default(input cell_count_t c);
        case (c)
            2'h0: svf_default = `SVF_DEF_1S;
            2'h1: svf_default = `SVF_DEF_2S;
            2'h2: svf_default = `SVF_DEF_3S;
            default: svf_default = `SVF_DEF_4S;
        endcase
    endfunction : svf_default

    assign pc.wr_en = wr_en_in;
    assign pc.addr = wr_addr_in;
    assign pc.data = wr_data_in;

    byte_pair_collector byte_pair_collector_i (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pc(pc)
    );

    // strap pin synchroniser, one three-stage chain per bit
    // a new level counts only once the last two stages agree, so a bouncing strap
    // cannot pick a wrong default; only the second stage reads the first
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_strap
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    strap_sync[gi] <= 3'h0;
                    strap_bit[gi] <= 1'b0;
                end else begin
                    strap_sync[gi] <= {strap_sync[gi][1:0], cell_count_select_pin_in[gi]};
                    if (strap_sync[gi][2] == strap_sync[gi][1]) begin
                        strap_bit[gi] <= strap_sync[gi][2];
                    end
                end
            end
        end
    endgenerate

    // settled strap code picks both defaults
    assign cells = {strap_bit[1], strap_bit[0]};
    assign default_cvl = cvl_default(cells);
    assign default_svf = svf_default(cells);
    // reserved low bits dropped before the range checks; the zero test sees the raw word
    assign cvl_word = pc.word & `CVL_FIELD_MASK;
    assign svf_word = pc.word & `SVF_FIELD_MASK;
    assign cvl_ok = ((pc.word[15:8] & `CVL_RSVD_HI_MASK) == 8'h00)
        && cvl_word >= `CVL_MIN_MV && cvl_word <= `CVL_MAX_MV;
    assign svf_ok = ((pc.word[15:8] & `SVF_RSVD_HI_MASK) == 8'h00)
        && svf_word >= `SVF_MIN_MV && svf_word <= `SVF_MAX_MV;

    // defaults load a few cycles after reset, once the strap has settled in the synchroniser
    logic [2:0] settle;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            settle <= 3'h0;
            first_cycle <= 1'b1;
        end else begin
            if (settle != `STRAP_SETTLE) begin
                settle <= settle + 3'h1;
            end
            first_cycle <= (settle != `STRAP_SETTLE);
        end
    end

    // charge voltage limit: complete, valid pairs only; zero reloads the default
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            charge_voltage_limit_out <= 16'h0000;
        end else if (first_cycle) begin
            charge_voltage_limit_out <= default_cvl;
        end else if (pc.done && pc.base == `CVL_ADDR_LO) begin
            if (pc.word == 16'h0000) begin
                charge_voltage_limit_out <= default_cvl;
            end else if (cvl_ok) begin
                charge_voltage_limit_out <= cvl_word;
            end
        end
    end

    // system voltage floor
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            system_voltage_floor_out <= 16'h0000;
        end else if (first_cycle) begin
            system_voltage_floor_out <= default_svf;
        end else if (pc.done && pc.base == `SVF_ADDR_LO && svf_ok) begin
            system_voltage_floor_out <= svf_word;
        end
    end

    // mirror of the current setpoint; zero write on the voltage limit wins over a current write
    always_ff @(posedge clk_in) begin
        if (reset_in || !input_power_good_in) begin
            charge_current_setpoint_out <= 16'h0000;
        end else if (pc.done && pc.base == `CVL_ADDR_LO && pc.word == 16'h0000) begin
            charge_current_setpoint_out <= 16'h0000;
        end else if (pc.done && pc.base == `CCS_ADDR_LO) begin
            charge_current_setpoint_out <= pc.word;
        end
    end

    // charge runs from the cycle after a non-zero current write while power is good
    always_ff @(posedge clk_in) begin
        if (reset_in || !input_power_good_in) begin
            charge_enable_out <= 1'b0;
        end else if (pc.done && pc.base == `CVL_ADDR_LO && pc.word == 16'h0000) begin
            charge_enable_out <= 1'b0;
        end else if (pc.done && pc.base == `CCS_ADDR_LO) begin
            charge_enable_out <= (pc.word != 16'h0000);
        end
    end

    // regulation target follows the limit; the analog loop handles the charging case
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            regulation_target_out <= 16'h0000;
        end else begin
            regulation_target_out <= charge_voltage_limit_out;
        end
    end

    // byte read-back, unmapped addresses answer zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rd_data_out <= 8'h00;
        end else begin
            case (rd_addr_in)
                `CVL_ADDR_LO: rd_data_out <= charge_voltage_limit_out[7:0];
                `CVL_ADDR_HI: rd_data_out <= charge_voltage_limit_out[15:8];
                `SVF_ADDR_LO: rd_data_out <= system_voltage_floor_out[7:0];
                `SVF_ADDR_HI: rd_data_out <= system_voltage_floor_out[15:8];
                `CCS_ADDR_LO: rd_data_out <= charge_current_setpoint_out[7:0];
                `CCS_ADDR_HI: rd_data_out <= charge_current_setpoint_out[15:8];
                default: rd_data_out <= 8'h00;
            endcase
        end
    end

    // range checks wait for first_cycle to drop, the defaults are still loading before that
    a_limit_in_range: assert property (@(posedge clk_in) disable iff (reset_in)
        !first_cycle |-> charge_voltage_limit_out >= `CVL_MIN_MV && charge_voltage_limit_out <= `CVL_MAX_MV)
        else $error("charge limit out of range");
    a_floor_in_range: assert property (@(posedge clk_in) disable iff (reset_in)
        !first_cycle |-> system_voltage_floor_out >= `SVF_MIN_MV && system_voltage_floor_out <= `SVF_MAX_MV)
        else $error("floor out of range");
    a_limit_low_bits: assert property (@(posedge clk_in) disable iff (reset_in)
        charge_voltage_limit_out[3:0] == 4'h0) else $error("limit low bits set");
    a_floor_low_byte: assert property (@(posedge clk_in) disable iff (reset_in)
        system_voltage_floor_out[7:0] == 8'h00) else $error("floor low byte set");
    a_zero_reloads: assert property (@(posedge clk_in) disable iff (reset_in)
        (!first_cycle && pc.done && pc.base == `CVL_ADDR_LO && pc.word == 16'h0000)
        |=> charge_voltage_limit_out == $past(default_cvl) && charge_current_setpoint_out == 16'h0000)
        else $error("zero write did not reload");
    a_bad_limit_kept: assert property (@(posedge clk_in) disable iff (reset_in)
        (!first_cycle && pc.done && pc.base == `CVL_ADDR_LO && pc.word != 16'h0000 && !cvl_ok)
        |=> $stable(charge_voltage_limit_out)) else $error("invalid limit write applied");
    a_bad_floor_kept: assert property (@(posedge clk_in) disable iff (reset_in)
        (!first_cycle && pc.done && pc.base == `SVF_ADDR_LO && !svf_ok)
        |=> $stable(system_voltage_floor_out)) else $error("invalid floor write applied");
    a_current_starts: assert property (@(posedge clk_in) disable iff (reset_in)
        (input_power_good_in && pc.done && pc.base == `CCS_ADDR_LO && pc.word != 16'h0000)
        ##1 input_power_good_in |-> charge_enable_out) else $error("charge did not start");
    // without input power no charge may run and the current mirror stays cleared
    a_power_loss_stops: assert property (@(posedge clk_in) disable iff (reset_in)
        !input_power_good_in |=> !charge_enable_out && charge_current_setpoint_out == 16'h0000)
        else $error("charge kept without input power");
    a_target_follows: assert property (@(posedge clk_in) disable iff (reset_in)
        1'b1 |=> regulation_target_out == $past(charge_voltage_limit_out))
        else $error("target not following limit");
endmodule : charge_voltage_setpoint_regs

// >>> verif/host_model.sv
// host side model: byte writes and byte reads on the setpoint bank's control port
`timescale 1ns/100ps
module host_model (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    output logic wr_en_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic [7:0] rd_addr_out
);
    // idle bus from time zero
    initial begin
        wr_en_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
        rd_addr_out = 8'h00;
    end
    // one strobe: launched on a falling edge, taken at the rising edge after
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        wr_en_out = 1'b1;
        wr_addr_out = addr;
        wr_data_out = data;
        @(negedge clk_in);
        wr_en_out = 1'b0;
        wr_data_out = ~data; // released bus shows no stale byte
    endtask : write_byte
    // low byte at the even address first, then the high byte at the odd one
    task automatic write_word(input logic [7:0] base, input logic [15:0] word);
        write_byte(base, word[7:0]);
        write_byte(base + 8'h01, word[15:8]);
        repeat (4) @(negedge clk_in);
    endtask : write_word
    // read data is registered, so it is taken one falling edge later
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_in);
        rd_addr_out = addr;
        @(negedge clk_in);
        data = rd_data_in;
    endtask : read_byte
endmodule : host_model

// >>> verif/charge_voltage_setpoint_regs_tb.sv
// self-checking bench for the charge voltage setpoint bank
`timescale 1ns/100ps
`include "chg_setpoint_consts.svh"
module charge_voltage_setpoint_regs_tb;
    import chg_setpoint_pkg::*;
    logic clk_in, reset_in, input_power_good_in, wr_en_in, charge_enable_out;
    cell_count_t cell_count_select_pin_in;
    logic [7:0] wr_addr_in, wr_data_in, rd_addr_in, rd_data_out, rd_byte;
    word_t charge_voltage_limit_out, system_voltage_floor_out;
    word_t charge_current_setpoint_out, regulation_target_out;
    int n_fail = 0;
    int check_count = 0;
    word_t cvl_def [4] = '{`CVL_DEF_1S, `CVL_DEF_2S, `CVL_DEF_3S, `CVL_DEF_4S};
    word_t svf_def [4] = '{`SVF_DEF_1S, `SVF_DEF_2S, `SVF_DEF_3S, `SVF_DEF_4S};

    charge_voltage_setpoint_regs charge_voltage_setpoint_regs_i (.clk_in(clk_in), .reset_in(reset_in),
        .cell_count_select_pin_in(cell_count_select_pin_in), .input_power_good_in(input_power_good_in),
        .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .rd_addr_in(rd_addr_in),
        .rd_data_out(rd_data_out), .charge_voltage_limit_out(charge_voltage_limit_out),
        .system_voltage_floor_out(system_voltage_floor_out),
        .charge_current_setpoint_out(charge_current_setpoint_out),
        .charge_enable_out(charge_enable_out), .regulation_target_out(regulation_target_out));
    host_model host_model_i (.clk_in(clk_in), .rd_data_in(rd_data_out), .wr_en_out(wr_en_in),
        .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in), .rd_addr_out(rd_addr_in));

    // 20 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic check(input word_t seen, input word_t exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // strap is set during reset; defaults settle within a few cycles after release
    task automatic do_reset(input cell_count_t cells);
        @(negedge clk_in);
        reset_in = 1'b1;
        cell_count_select_pin_in = cells;
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask : do_reset

    task automatic scen_defaults();
        for (int c = 0; c < 4; c++) begin
            do_reset(cell_count_t'(c));
            check(charge_voltage_limit_out, cvl_def[c]);
            check(system_voltage_floor_out, svf_def[c]);
            check(regulation_target_out, cvl_def[c]);
        end
    endtask : scen_defaults

    // boundaries of the limit range, reserved bits high and low
    task automatic scen_limit();
        host_model_i.write_word(`CVL_ADDR_LO, 16'h204F);
        check(charge_voltage_limit_out, 16'h2040);
        check(regulation_target_out, 16'h2040);
        host_model_i.read_byte(`CVL_ADDR_HI, rd_byte);
        check(word_t'(rd_byte), 16'h0020);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h0400);
        check(charge_voltage_limit_out, 16'h0400);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h03F0);
        check(charge_voltage_limit_out, 16'h0400);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h4B00);
        check(charge_voltage_limit_out, 16'h4B00);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h4B10);
        check(charge_voltage_limit_out, 16'h4B00);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h8400);
        check(charge_voltage_limit_out, 16'h4B00);
    endtask : scen_limit

    task automatic scen_floor();
        host_model_i.write_word(`SVF_ADDR_LO, 16'h05FF);
        check(system_voltage_floor_out, 16'h0500);
        host_model_i.write_word(`SVF_ADDR_LO, 16'h0300);
        check(system_voltage_floor_out, 16'h0500);
        host_model_i.write_word(`SVF_ADDR_LO, 16'h3F00);
        check(system_voltage_floor_out, 16'h3F00);
        host_model_i.write_word(`SVF_ADDR_LO, 16'h4400);
        check(system_voltage_floor_out, 16'h3F00);
        host_model_i.write_word(`SVF_ADDR_LO, 16'h0400);
        check(system_voltage_floor_out, 16'h0400);
    endtask : scen_floor

    // lone low byte changes nothing; a second low byte replaces the first; lone high byte dropped
    task automatic scen_partial();
        host_model_i.write_byte(`CVL_ADDR_LO, 8'h80);
        repeat (4) @(negedge clk_in);
        check(charge_voltage_limit_out, 16'h4B00);
        host_model_i.write_byte(`CVL_ADDR_LO, 8'h00);
        host_model_i.write_byte(`CVL_ADDR_HI, 8'h30);
        repeat (4) @(negedge clk_in);
        check(charge_voltage_limit_out, 16'h3000);
        host_model_i.write_byte(`CVL_ADDR_HI, 8'h25);
        repeat (4) @(negedge clk_in);
        check(charge_voltage_limit_out, 16'h3000);
    endtask : scen_partial

    // current before voltage starts charge; a zero limit word stops it; power loss stops it too
    task automatic scen_charge();
        do_reset(2'h1);
        input_power_good_in = 1'b1;
        host_model_i.write_word(`CCS_ADDR_LO, 16'h0200);
        check(word_t'(charge_enable_out), 16'h0001);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h0000);
        check(charge_voltage_limit_out, cvl_def[1]);
        check(charge_current_setpoint_out, 16'h0000);
        check(word_t'(charge_enable_out), 16'h0000);
        check(regulation_target_out, cvl_def[1]);
        host_model_i.write_word(`CVL_ADDR_LO, 16'h2040); // voltage first
        host_model_i.write_word(`CCS_ADDR_LO, 16'h0200);
        check(charge_current_setpoint_out, 16'h0200);
        check(charge_voltage_limit_out, 16'h2040);
        check(word_t'(charge_enable_out), 16'h0001);
        input_power_good_in = 1'b0;
        host_model_i.write_word(`CCS_ADDR_LO, 16'h0100);
        check(charge_current_setpoint_out, 16'h0000);
        check(word_t'(charge_enable_out), 16'h0000);
    endtask : scen_charge

    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk_in);
        n_fail++;
        conclude();
    end

    initial begin
        reset_in = 1'b1;
        cell_count_select_pin_in = 2'h0;
        input_power_good_in = 1'b0;
        scen_defaults();
        scen_limit();
        scen_floor();
        scen_partial();
        scen_charge();
        conclude();
    end
endmodule : charge_voltage_setpoint_regs_tb
